// ==== src/thmi_defines.svh ====
/*
 * Constants of the touch host message interface: clock rate, reset times, object field addresses,
 * command codes, report identifiers, status bits and message store geometry.
 * Assumes it is included by bare name wherever these constants are needed.
 */
`ifndef THMI_DEFINES_SVH
`define THMI_DEFINES_SVH

// Core clock rate in hertz and the start-up times in milliseconds.
`define THMI_CLK_HZ        100000000
`define THMI_POR_MS        40
`define THMI_SWRST_MS      64
`define THMI_CNT_W         23

// Object field addresses seen by the link front end.
`define THMI_ADDR_CMD      8'h00
`define THMI_ADDR_ENABLE   8'h01
`define THMI_ADDR_SUPPLY   8'h02

// Command codes accepted by the command processor object.
`define THMI_CMD_RESET     8'h01
`define THMI_CMD_BACKUP    8'h02
`define THMI_CMD_CALIB     8'h03
`define THMI_CMD_SELFTEST  8'h04

// Report identifiers and status bits carried by messages.
`define THMI_RID_CMDPROC   8'h01
`define THMI_RID_SELFTEST  8'h02
`define THMI_RID_NONE      8'hFF
`define THMI_STS_RESET     8'h80
`define THMI_STS_OVERFLOW  8'h40
`define THMI_STS_CALIB     8'h10
`define THMI_STS_CFGERR    8'h08
`define THMI_STS_PASS      8'hFE

// Bits of the optional object enable field.
`define THMI_EN_SELFTEST   0
`define THMI_EN_DIAG       1

// Reset values of the object fields.
`define THMI_FIELD_RST     8'h00

// Message store geometry.
`define THMI_MSG_DEPTH     8
`define THMI_MSG_AW        3

`endif

// ==== src/thmi_pkg.sv ====
/*
 * Types and helpers of the touch host message interface.
 * Assumes thmi_defines.svh sits on the include path.
 */
`include "thmi_defines.svh"

package thmi_pkg;

   // Sequencer states, Gray coded along boot, run and software reset.
   typedef enum logic [1:0] {
      THMI_BOOT  = 2'b00,
      THMI_RUN   = 2'b01,
      THMI_SWRST = 2'b11
   } thmi_state_t;

   // One message: report identifier in the upper byte, status in the lower.
   typedef logic [15:0] thmi_msg_t;

   // Builds a message from its report identifier and status byte.
   function automatic thmi_msg_t thmi_make_msg(input logic [7:0] rid, input logic [7:0] sts);
      return {rid, sts};
   endfunction

endpackage : thmi_pkg

// ==== src/thmi_msg_store.sv ====
/*
 * Message store: a small first-in first-out array of queued messages.
 * Assumes the caller never pushes when full and never pops when empty; flush empties it.
 */
`include "thmi_defines.svh"

module thmi_msg_store
   import thmi_pkg::*;
(
   // Clock and reset.
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   // Write side.
   input  wire logic             push_i,
   input  wire thmi_pkg::thmi_msg_t push_data_i,
   input  wire logic             flush_i,
   // Read side.
   input  wire logic             pop_i,
   output thmi_pkg::thmi_msg_t   head_o,
   output logic                  empty_o,
   output logic                  full_o
);

   thmi_msg_t               mem [`THMI_MSG_DEPTH];
   logic [`THMI_MSG_AW-1:0] wr_ptr;
   logic [`THMI_MSG_AW-1:0] rd_ptr;
   logic [`THMI_MSG_AW:0]   count;

   // Storage array, written on each accepted push.
   always_ff @(posedge core_clk_i) begin
      if (push_i && !full_o) begin
         mem[wr_ptr] <= push_data_i;
      end
   end

   // Pointers and occupancy; flush drops every queued message.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (flush_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push_i && !full_o) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop_i && !empty_o) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (`THMI_MSG_AW+1)'(push_i && !full_o) - (`THMI_MSG_AW+1)'(pop_i && !empty_o);
      end
   end

   // Head word and flags.
   assign head_o  = mem[rd_ptr];
   assign empty_o = (count == '0);
   assign full_o  = (count == (`THMI_MSG_AW+1)'(`THMI_MSG_DEPTH));

endmodule // thmi_msg_store

// ==== src/thmi_core.sv ====
/*
 * Host message interface core of a touch controller: object field writes, command execution,
 * message queue with an active-low pending line, diagnostic raw data reads and start-up timing.
 * Assumes a link front end that turns host bus transfers into field writes and message reads,
 * and a sense engine that reports calibration and self-test completion.
 */
// Behaviour
// [RQ1] After power-up the pending line goes low: a reset message waits.
// [RQ2] Host treats the device as faulty if the pending line never falls.
// [RQ3] Host reads all messages after power-up or reset to confirm life.
// [RQ4] Host checks start-up messages for a reported configuration error.
// [RQ5] Host reads every object start address from the object table first.
// [RQ6] Host derives report identifiers from the object table.
// [RQ7] Commands written to the command processor object are executed.
// [RQ8] Host configures by field writes; disabled optional objects are ignored.
// [RQ9] Status reaches the host only through messages read from the store.
// [RQ10] Pending line asserts whenever a new message is available.
// [RQ11] Host waits on the pending line instead of polling.
// [RQ12] Logic runs from the internal oscillator; no external clock is needed.
// [RQ13] Host writes the analog supply level into the sense engine config.
// [RQ14] Raw data readable via diagnostic object; self-test runs via its object.
// [RQ15] Pending line falls about 40 ms after power-up or hardware reset.
// [RQ16] Pending line falls about 64 ms after a software reset command.
// [RQ17] Every object field defaults to zero, leaving functions disabled.
// [RQ18] Pending line returns high once every queued message has been read.
`include "thmi_defines.svh"

module thmi_core
   import thmi_pkg::*;
#(
   parameter int unsigned POR_CYCLES   = `THMI_POR_MS * (`THMI_CLK_HZ / 1000),
   parameter int unsigned SWRST_CYCLES = `THMI_SWRST_MS * (`THMI_CLK_HZ / 1000)
)
(
   // Clock from the internal oscillator and reset.
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // Object field writes from the link front end.
   input  wire logic        fld_wr_i,
   input  wire logic [7:0]  fld_addr_i,
   input  wire logic [7:0]  fld_data_i,
   // Message object reads.
   input  wire logic        msg_rd_i,
   output thmi_pkg::thmi_msg_t msg_data_o,
   output logic             msg_valid_o,
   output logic             message_pending_n_o,
   // Diagnostic object reads.
   input  wire logic        diag_rd_i,
   input  wire logic [15:0] raw_data_i,
   output logic [15:0]      diag_data_o,
   // Sense engine events.
   input  wire logic        calib_done_i,
   input  wire logic        selftest_done_i,
   input  wire logic [7:0]  selftest_code_i,
   // Controls to the rest of the device.
   output logic             soft_reset_o,
   output logic             backup_o,
   output logic             calibrate_o,
   output logic             selftest_start_o,
   output logic [7:0]       obj_enable_o,
   output logic [7:0]       supply_level_o
);

   thmi_state_t          state;
   logic [`THMI_CNT_W-1:0] cnt;
   logic                 cmd_wr;
   logic                 rst_req, cfg_req, cal_req, st_req, ovf_pend;
   logic [7:0]           cfg_sts, st_sts;
   logic                 push, pop, empty, full, flush;
   thmi_msg_t            push_data, head;

   // A write to the command field while running.
   assign cmd_wr = fld_wr_i && (fld_addr_i == `THMI_ADDR_CMD) && (state == THMI_RUN);

   // Start-up sequencer on the internal oscillator clock, with the boot and software reset waits. [RQ12]
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= THMI_BOOT;
         cnt   <= `THMI_CNT_W'(POR_CYCLES - 1);
      end else begin
         case (state)
            THMI_BOOT, THMI_SWRST: begin
               if (cnt == '0) begin
                  state <= THMI_RUN;                          // [RQ15] [RQ16]
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            THMI_RUN: begin
               if (cmd_wr && fld_data_i == `THMI_CMD_RESET) begin
                  state <= THMI_SWRST;                        // [RQ7] [RQ16]
                  cnt   <= `THMI_CNT_W'(SWRST_CYCLES - 1);
               end
            end
            default: begin
               state <= THMI_BOOT;
               cnt   <= `THMI_CNT_W'(POR_CYCLES - 1);
            end
         endcase
      end
   end

   // Object fields; zero on any reset so optional functions start disabled. [RQ17]
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         obj_enable_o   <= `THMI_FIELD_RST;
         supply_level_o <= `THMI_FIELD_RST;
      end else if (state == THMI_SWRST) begin
         obj_enable_o   <= `THMI_FIELD_RST;                   // [RQ17]
         supply_level_o <= `THMI_FIELD_RST;
      end else if (fld_wr_i && state == THMI_RUN) begin
         if (fld_addr_i == `THMI_ADDR_ENABLE) begin
            obj_enable_o <= fld_data_i;                       // [RQ8]
         end
         if (fld_addr_i == `THMI_ADDR_SUPPLY) begin
            supply_level_o <= fld_data_i;
         end
      end
   end

   // Command pulses; self-test is ignored while its object is disabled.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         soft_reset_o     <= 1'b0;
         backup_o         <= 1'b0;
         calibrate_o      <= 1'b0;
         selftest_start_o <= 1'b0;
      end else begin
         soft_reset_o     <= cmd_wr && fld_data_i == `THMI_CMD_RESET;   // [RQ7]
         backup_o         <= cmd_wr && fld_data_i == `THMI_CMD_BACKUP;
         calibrate_o      <= cmd_wr && fld_data_i == `THMI_CMD_CALIB;
         selftest_start_o <= cmd_wr && fld_data_i == `THMI_CMD_SELFTEST
                             && obj_enable_o[`THMI_EN_SELFTEST];        // [RQ8] [RQ14]
      end
   end

   // Pending message requests; a new event wins over the clear of the same cycle.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rst_req  <= 1'b0;
         cfg_req  <= 1'b0;
         cal_req  <= 1'b0;
         st_req   <= 1'b0;
         cfg_sts  <= `THMI_FIELD_RST;
         st_sts   <= `THMI_FIELD_RST;
      end else if (state != THMI_RUN) begin
         rst_req <= (cnt == '0);                              // [RQ1] [RQ15] [RQ16]
         cfg_req <= 1'b0;
         cal_req <= 1'b0;
         st_req  <= 1'b0;
      end else begin
         if (push && rst_req) begin
            rst_req <= 1'b0;
         end
         if (backup_o) begin
            cfg_req <= 1'b1;
            cfg_sts <= (supply_level_o == `THMI_FIELD_RST) ? `THMI_STS_CFGERR : `THMI_FIELD_RST;
         end else if (push && !rst_req && cfg_req) begin
            cfg_req <= 1'b0;
         end
         if (calib_done_i) begin
            cal_req <= 1'b1;
         end else if (push && !rst_req && !cfg_req && cal_req) begin
            cal_req <= 1'b0;
         end
         if (selftest_done_i && obj_enable_o[`THMI_EN_SELFTEST]) begin
            st_req <= 1'b1;                                   // [RQ8] [RQ14]
            st_sts <= selftest_code_i;
         end else if (push && !rst_req && !cfg_req && !cal_req && st_req) begin
            st_req <= 1'b0;
         end
      end
   end

   // One message enters the store per cycle, in fixed priority, only while room remains.
   assign push = (state == THMI_RUN) && !full && (rst_req || cfg_req || cal_req || st_req);
   always_comb begin
      if (rst_req) begin
         push_data = thmi_make_msg(`THMI_RID_CMDPROC, `THMI_STS_RESET | cfg_sts);  // [RQ9]
      end else if (cfg_req) begin
         push_data = thmi_make_msg(`THMI_RID_CMDPROC, cfg_sts | (ovf_pend ? `THMI_STS_OVERFLOW : 8'h00));
      end else if (cal_req) begin
         push_data = thmi_make_msg(`THMI_RID_CMDPROC, `THMI_STS_CALIB);
      end else begin
         push_data = thmi_make_msg(`THMI_RID_SELFTEST, st_sts);
      end
   end

   // Remembers that an event arrived while the store was full.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ovf_pend <= 1'b0;
      end else if (full && (calib_done_i || selftest_done_i)) begin
         ovf_pend <= 1'b1;
      end else if (push && !rst_req && cfg_req) begin
         ovf_pend <= 1'b0;
      end
   end

   assign flush = (state == THMI_SWRST);
   assign pop   = msg_rd_i && !empty;

   thmi_msg_store u_store (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .push_i      (push),
      .push_data_i (push_data),
      .flush_i     (flush),
      .pop_i       (pop),
      .head_o      (head),
      .empty_o     (empty),
      .full_o      (full)
   );

   // Message reads and the pending line; an empty store answers with the null report identifier.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         msg_data_o          <= thmi_make_msg(`THMI_RID_NONE, `THMI_FIELD_RST);
         msg_valid_o         <= 1'b0;
         message_pending_n_o <= 1'b1;
      end else begin
         if (msg_rd_i) begin
            msg_data_o <= empty ? thmi_make_msg(`THMI_RID_NONE, `THMI_FIELD_RST) : head;  // [RQ9]
         end
         msg_valid_o         <= pop;
         message_pending_n_o <= !((state == THMI_RUN) && !empty);  // [RQ10] [RQ18]
      end
   end

   // Diagnostic raw data captured on each read, zero for a read while the diagnostic object is disabled.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         diag_data_o <= 16'h0000;
      end else if (diag_rd_i) begin
         diag_data_o <= obj_enable_o[`THMI_EN_DIAG] ? raw_data_i : 16'h0000;  // [RQ14] [RQ8]
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   AST_BOOT_TO_RUN: assert property ((state != THMI_RUN && cnt == '0) |=> (state == THMI_RUN && rst_req)) // [RQ15]
      else $error("Start-up wait did not end with a reset message request.");
   AST_PEND_LOW: assert property ((state == THMI_RUN && !empty) |=> !message_pending_n_o) // [RQ10]
      else $error("Pending line stayed high with a queued message.");
   AST_FIRST_MSG: assert property ((state == THMI_RUN && rst_req && !full) |=> ##1 !message_pending_n_o) // [RQ1]
      else $error("Reset message did not pull the pending line low.");
   AST_PEND_RELEASE: assert property ((empty) |=> message_pending_n_o) // [RQ18]
      else $error("Pending line low with an empty store.");
   AST_SWRST: assert property ((cmd_wr && fld_data_i == `THMI_CMD_RESET) |=> (state == THMI_SWRST && soft_reset_o
      && cnt == `THMI_CNT_W'(SWRST_CYCLES - 1))) // [RQ16]
      else $error("Software reset command not executed.");
   AST_FIELDS_ZERO: assert property ((state == THMI_SWRST) |=> (obj_enable_o == 8'h00 && supply_level_o == 8'h00)) // [RQ17]
      else $error("Object fields not cleared by software reset.");
   AST_CALIB: assert property ((cmd_wr && fld_data_i == `THMI_CMD_CALIB) |=> calibrate_o) // [RQ7]
      else $error("Calibrate command not executed.");
   AST_ST_IGNORED: assert property ((cmd_wr && !obj_enable_o[`THMI_EN_SELFTEST]) |=> !selftest_start_o) // [RQ8]
      else $error("Self-test started on a disabled object.");
   AST_DIAG: assert property (diag_rd_i |=> diag_data_o == ($past(obj_enable_o[`THMI_EN_DIAG]) ? $past(raw_data_i)
      : 16'h0000)) // [RQ14]
      else $error("Diagnostic read returned wrong data.");
   AST_READ_EMPTY: assert property ((msg_rd_i && empty) |=> (msg_data_o[15:8] == `THMI_RID_NONE && !msg_valid_o)) // [RQ9]
      else $error("Empty message read returned a report.");

   COV_RESET_MSG: cover property (state == THMI_RUN && push && rst_req);
   COV_SWRST: cover property (state == THMI_SWRST ##[1:300] state == THMI_RUN);
   COV_DRAIN: cover property (!message_pending_n_o ##1 msg_rd_i ##2 message_pending_n_o);

endmodule // thmi_core

// ==== tb/thmi_sense_model.sv ====
/*
 * Sense engine partner model: answers calibrate and self-test requests after fixed delays
 * and offers a fixed raw acquisition word.
 * Assumes one clock and the active-high asynchronous reset shared with the core.
 */
module thmi_sense_model #(
   parameter int unsigned CAL_DLY = 5,
   parameter int unsigned ST_DLY  = 7,
   parameter logic [7:0]  ST_CODE = 8'hA5,
   parameter logic [15:0] RAW     = 16'h5A3C
)
(
   // Clock and reset.
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // Requests from the core.
   input  wire logic        calibrate_i,
   input  wire logic        selftest_start_i,
   // Answers to the core.
   output logic             calib_done_o,
   output logic             selftest_done_o,
   output logic [7:0]       selftest_code_o,
   output logic [15:0]      raw_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned cal_cnt;
   int unsigned st_cnt;

   // Calibration runs for CAL_DLY cycles, then reports completion once.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) cal_cnt <= 0;
      else if (calibrate_i) cal_cnt <= CAL_DLY;
      else if (cal_cnt != 0) cal_cnt <= cal_cnt - 1;
   end

   // Self-test runs for ST_DLY cycles, then reports its result once.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) st_cnt <= 0;
      else if (selftest_start_i) st_cnt <= ST_DLY;
      else if (st_cnt != 0) st_cnt <= st_cnt - 1;
   end

   // The code is only meaningful with done, so it shows the inverse otherwise.
   assign calib_done_o    = (cal_cnt == 1);
   assign selftest_done_o = (st_cnt == 1);
   assign selftest_code_o = selftest_done_o ? ST_CODE : ~ST_CODE;
   assign raw_data_o      = RAW;
endmodule // thmi_sense_model

// ==== tb/thmi_core_tb_top.sv ====
/*
 * Self-checking bench of the host message interface core with a sense engine model.
 * Assumes shortened start-up counts; the bench plays the link front end.
 */
module thmi_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import thmi_pkg::*;
   localparam int P = 20;
   localparam int S = 30;
   // Object start addresses the host keeps before any other traffic.
   localparam logic [7:0] A_EN  = 8'h01;
   localparam logic [7:0] A_SUP = 8'h02;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [3:0] p; logic [15:0] m; logic h;} thmi_tb_row_t;

   logic core_clk_i = 0, rst_i = 1, fld_wr_i = 0, msg_rd_i = 0, diag_rd_i = 0;
   logic [7:0] fld_addr_i = 8'h00, fld_data_i = 8'h00, obj_enable_o, supply_level_o, st_code;
   logic [15:0] raw_data, diag_data_o;
   thmi_msg_t msg_data_o;
   logic msg_valid_o, message_pending_n_o, soft_reset_o, backup_o, calibrate_o, selftest_start_o;
   logic cal_done, st_done;
   int fails = 0, n_checks = 0, n, pc[4], p0[4];
   logic [7:0] en_x, sup_x;
   thmi_tb_row_t rows[9] = '{
      '{8'h00, 8'h02, 4'h4, 16'h0108, 1'b1}, '{8'h02, 8'h21, 4'h0, 16'h0000, 1'b0},
      '{8'h00, 8'h02, 4'h4, 16'h0100, 1'b1}, '{8'h00, 8'h03, 4'h2, 16'h0110, 1'b1},
      '{8'h00, 8'h04, 4'h0, 16'h0000, 1'b0}, '{8'h00, 8'h07, 4'h0, 16'h0000, 1'b0},
      '{8'h01, 8'h03, 4'h0, 16'h0000, 1'b0}, '{8'h00, 8'h04, 4'h1, 16'h02A5, 1'b1},
      '{8'h09, 8'h55, 4'h0, 16'h0000, 1'b0}};

   // Clock at 100 MHz.
   always #5 core_clk_i = ~core_clk_i;

   // Counts every command pulse so that no exact cycle of the answer is assumed.
   always @(posedge core_clk_i) begin
      pc[3] += int'(soft_reset_o === 1'b1);
      pc[2] += int'(backup_o === 1'b1);
      pc[1] += int'(calibrate_o === 1'b1);
      pc[0] += int'(selftest_start_o === 1'b1);
   end

   thmi_core #(.POR_CYCLES(P), .SWRST_CYCLES(S)) i_thmi_core (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .fld_wr_i(fld_wr_i), .fld_addr_i(fld_addr_i),
      .fld_data_i(fld_data_i), .msg_rd_i(msg_rd_i), .msg_data_o(msg_data_o), .msg_valid_o(msg_valid_o),
      .message_pending_n_o(message_pending_n_o), .diag_rd_i(diag_rd_i), .raw_data_i(raw_data),
      .diag_data_o(diag_data_o), .calib_done_i(cal_done), .selftest_done_i(st_done),
      .selftest_code_i(st_code), .soft_reset_o(soft_reset_o), .backup_o(backup_o),
      .calibrate_o(calibrate_o), .selftest_start_o(selftest_start_o), .obj_enable_o(obj_enable_o),
      .supply_level_o(supply_level_o));

   thmi_sense_model #(.ST_CODE(8'hA5), .RAW(16'h5A3C)) i_thmi_sense_model (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .calibrate_i(calibrate_o),
      .selftest_start_i(selftest_start_o), .calib_done_o(cal_done), .selftest_done_o(st_done),
      .selftest_code_o(st_code), .raw_data_o(raw_data));

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One field write: strobe held for exactly one sampling edge.
   task automatic wr_fld(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      fld_wr_i <= 1'b1;
      fld_addr_i <= a;
      fld_data_i <= d;
      @(posedge core_clk_i);
      fld_wr_i <= 1'b0;
   endtask

   // Reads k messages back to back and compares each answer in its own cycle.
   task automatic rd_msg(input int k, input logic [15:0] e0, input logic [15:0] e1, input logic v);
      @(posedge core_clk_i);
      msg_rd_i <= 1'b1;
      for (int i = 0; i < k; i++) begin
         @(posedge core_clk_i);
         if (i == k - 1) msg_rd_i <= 1'b0;
         #1;
         chk("msg_data_o", (i == 0) ? e0 : e1, msg_data_o);
         chk("msg_valid_o", {15'h0, v}, {15'h0, msg_valid_o});
         if (i < k - 1) chk("pending kept", 16'h0, {15'h0, message_pending_n_o});
      end
      repeat (2) @(posedge core_clk_i);
      #1 chk("pending released", 16'h1, {15'h0, message_pending_n_o});
   endtask

   // Waits on the pending line, bounded; n returns the cycles waited.
   task automatic wait_pend(input int bound);
      for (n = 1; n <= bound; n++) begin
         @(posedge core_clk_i);
         #1;
         if (message_pending_n_o === 1'b0) return;
      end
      chk("pending wait", 16'h0, 16'h1);
      results();
   endtask

   // Holds reset, checks reset values, then checks boot timing and the reset message.
   task automatic reset_boot(input int cyc);
      @(posedge core_clk_i);
      rst_i <= 1'b1;
      repeat (cyc) @(posedge core_clk_i);
      #1 chk("pending in reset", 16'h1, {15'h0, message_pending_n_o});
      chk("msg in reset", 16'hFF00, msg_data_o);
      chk("fields in reset", 16'h0, {obj_enable_o, supply_level_o});
      chk("diag in reset", 16'h0, diag_data_o);
      @(posedge core_clk_i);
      rst_i <= 1'b0;
      wr_fld(8'h02, 8'h77);
      wait_pend(100);
      chk("boot cycles", 16'h1, {15'h0, n + 2 >= P + 1 && n + 2 <= P + 3});
      chk("boot write ignored", 16'h0, {8'h0, supply_level_o});
      rd_msg(1, 16'h0180, 16'h0, 1'b1);
      rd_msg(1, 16'hFF00, 16'h0, 1'b0);
      en_x = 8'h00;
      sup_x = 8'h00;
      $display("test reset and boot done");
   endtask

   // One diagnostic read compared with the expected word.
   task automatic diag(input logic [15:0] e);
      @(posedge core_clk_i);
      diag_rd_i <= 1'b1;
      @(posedge core_clk_i);
      diag_rd_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      #1 chk("diag_data_o", e, diag_data_o);
   endtask

   initial begin
      pc = '{0, 0, 0, 0};
      reset_boot(16);
      diag(16'h0000);
      foreach (rows[r]) begin
         p0 = pc;
         wr_fld(rows[r].a, rows[r].d);
         if (rows[r].a == A_EN) en_x = rows[r].d;
         if (rows[r].a == A_SUP) sup_x = rows[r].d;
         repeat (3) @(posedge core_clk_i);
         #1;
         for (int b = 0; b < 4; b++) chk("command pulses", {15'h0, rows[r].p[b]}, 16'(pc[b] - p0[b]));
         chk("enable and supply", {en_x, sup_x}, {obj_enable_o, supply_level_o});
         if (rows[r].h) begin
            wait_pend(40);
            rd_msg(1, rows[r].m, 16'h0, 1'b1);
         end else begin
            repeat (20) @(posedge core_clk_i);
            #1 chk("no message", 16'h1, {15'h0, message_pending_n_o});
         end
      end
      $display("test command table done");
      diag(16'h5A3C);
      wr_fld(8'h01, 8'h00);
      diag(16'h0000);
      $display("test diagnostic done");
      wr_fld(8'h00, 8'h02);
      wr_fld(8'h00, 8'h03);
      repeat (20) @(posedge core_clk_i);
      rd_msg(2, 16'h0100, 16'h0110, 1'b1);
      $display("test back to back done");
      // Nine calibrations overfill the store; the next backup report carries the overflow bit.
      repeat (9) begin
         wr_fld(8'h00, 8'h03);
         repeat (10) @(posedge core_clk_i);
      end
      wr_fld(8'h00, 8'h02);
      repeat (10) @(posedge core_clk_i);
      for (int i = 0; i < 10; i++) begin
         @(posedge core_clk_i);
         msg_rd_i <= 1'b1;
         @(posedge core_clk_i);
         msg_rd_i <= 1'b0;
         #1 chk("overflow drain", (i == 8) ? 16'h0140 : 16'h0110, msg_data_o);
      end
      rd_msg(1, 16'hFF00, 16'h0, 1'b0);
      $display("test overflow done");
      p0 = pc;
      wr_fld(8'h00, 8'h01);
      repeat (3) @(posedge core_clk_i);
      #1 chk("soft reset pulse", 16'h1, 16'(pc[3] - p0[3]));
      chk("fields after soft reset", 16'h0, {obj_enable_o, supply_level_o});
      wait_pend(100);
      chk("soft reset cycles", 16'h1, {15'h0, n + 3 >= S + 1 && n + 3 <= S + 3});
      rd_msg(1, 16'h0180, 16'h0, 1'b1);
      $display("test soft reset done");
      wr_fld(8'h00, 8'h03);
      wait_pend(40);
      reset_boot(2);
      results();
   end
endmodule // thmi_core_tb_top
